//--- verilog/svd_ctrl.sv
// Purpose: Control for the on-chip supply level monitor
// Assumes: Comparator output synchronous to core_clk
// Notes: APB slave, zero wait states, sticky event interrupts
`timescale 1ns/10ps
`default_nettype none

module vdc_ctrl
    import vdc_pkg::*;
#(
    parameter int MIN_ON_CYCLES = MIN_ON_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic high_speed_oscillator,
    input wire logic supply_below,
    output logic detector_on,
    output logic [SEL_W-1:0] threshold_select,
    output logic [MV_W-1:0] threshold_mv,
    output logic threshold_valid,
    output logic irq
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic hit_sel;
    logic hit_ctl;
    logic hit_sts;
    logic hit_msk;
    logic mapped;

    function automatic logic [ADDR_W-1:0] baddr(input logic [15:0] idx);
        baddr = ADDR_W'({idx, 2'b00});
    endfunction

    assign hit_sel = (paddr == baddr(IDX_THRESHOLD_SELECT));
    assign hit_ctl = (paddr == baddr(IDX_DETECTOR_CONTROL_RESULT));
    assign hit_sts = (paddr == baddr(IDX_IRQ_STATUS));
    assign hit_msk = (paddr == baddr(IDX_IRQ_MASK));
    assign mapped = hit_sel | hit_ctl | hit_sts | hit_msk;
    assign wr_en = psel & penable & pwrite & mapped;
    assign rd_en = psel & penable & ~pwrite & mapped;
    // Every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ------------------------------------------------------------
    // Threshold select
    // ------------------------------------------------------------
    logic [SEL_W-1:0] sel_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sel_r <= SEL_RST;
        end else if (wr_en && hit_sel) begin
            sel_r <= pwdata[SEL_W-1:0];
        end
    end

    assign threshold_select = sel_r;

    // Level lookup; slow code 0 has no level and reports invalid
    logic [MV_W-1:0] mv_r;
    logic valid_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mv_r <= '0;
            valid_r <= 1'b0;
        end else if (high_speed_oscillator) begin
            mv_r <= LVL_FAST_MV[sel_r];
            valid_r <= 1'b1;
        end else begin
            mv_r <= LVL_SLOW_MV[sel_r];
            valid_r <= (sel_r != '0);
        end
    end

    assign threshold_mv = mv_r;
    assign threshold_valid = valid_r;

    // ------------------------------------------------------------
    // Detector control and result latch
    // ------------------------------------------------------------
    logic on_r;
    logic result_r;
    logic clear_on;

    // A falling write of the control bit while it was set
    assign clear_on = wr_en & hit_ctl & on_r & ~pwdata[ON_BIT];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            on_r <= 1'b0;
        end else if (wr_en && hit_ctl) begin
            on_r <= pwdata[ON_BIT];
        end
    end

    // Result bit of the write data is ignored on purpose
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            result_r <= 1'b0;
        end else if (clear_on) begin
            result_r <= supply_below;
        end
    end

    assign detector_on = on_r;

    // ------------------------------------------------------------
    // On-time tracking
    // ------------------------------------------------------------
    // Hardware only reports settling; early clears are not blocked
    vdc_state_t state_r;
    vdc_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic settled_evt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF: begin
                if (on_r) begin
                    state_nxt = ST_ON;
                end
            end
            ST_ON: begin
                if (!on_r) begin
                    state_nxt = ST_OFF;
                end else if (cnt_r >= CNT_W'(MIN_ON_CYCLES - 1)) begin
                    state_nxt = ST_SETTLED;
                end
            end
            ST_SETTLED: begin
                if (!on_r) begin
                    state_nxt = ST_OFF;
                end
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (state_r == ST_ON) begin
            cnt_r <= cnt_r + 1'b1;
        end else begin
            cnt_r <= '0;
        end
    end

    assign settled_evt = (state_r == ST_ON) && (state_nxt == ST_SETTLED);

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    logic [EVT_W-1:0] sts_r;
    logic [EVT_W-1:0] msk_r;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] w1c;

    always_comb begin
        evt = '0;
        evt[EVT_CAPTURE] = clear_on;
        evt[EVT_LOW] = clear_on & supply_below;
        evt[EVT_SETTLED] = settled_evt;
    end

    assign w1c = (wr_en && hit_sts) ? pwdata[EVT_W-1:0] : '0;

    // Set beats clear so a same-cycle event is never lost
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sts_r <= EVT_RST;
        end else begin
            sts_r <= (sts_r & ~w1c) | evt;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            msk_r <= EVT_RST;
        end else if (wr_en && hit_msk) begin
            msk_r <= pwdata[EVT_W-1:0];
        end
    end

    assign irq = |(sts_r & msk_r);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        prdata = '0;
        if (rd_en && hit_sel) begin
            prdata[SEL_W-1:0] = sel_r;
        end else if (rd_en && hit_ctl) begin
            prdata[ON_BIT] = on_r;
            prdata[RESULT_BIT] = result_r;
        end else if (rd_en && hit_sts) begin
            prdata[EVT_W-1:0] = sts_r;
        end else if (rd_en && hit_msk) begin
            prdata[EVT_W-1:0] = msk_r;
        end
    end

endmodule // vdc_ctrl

`default_nettype wire

//--- verilog/svd_pkg.sv
// Purpose: Shared constants for the supply level monitor control block
// Assumes: APB with 32-bit data, 40 MHz core clock
// Notes: Printed offsets are word indices; byte address is index * 4
package vdc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam logic [15:0] IDX_THRESHOLD_SELECT = 16'hff04;
    localparam logic [15:0] IDX_DETECTOR_CONTROL_RESULT = 16'hff05;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hff06;
    localparam logic [15:0] IDX_IRQ_MASK = 16'hff07;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int SEL_W = 3;
    localparam int ON_BIT = 0;
    localparam int RESULT_BIT = 1;
    localparam int EVT_W = 3;
    localparam int EVT_CAPTURE = 0;
    localparam int EVT_LOW = 1;
    localparam int EVT_SETTLED = 2;
    localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
    localparam logic [EVT_W-1:0] EVT_RST = 3'h0;

    // ------------------------------------------------------------
    // Threshold levels in millivolts
    // ------------------------------------------------------------
    localparam int MV_W = 12;
    localparam logic [MV_W-1:0] LVL_FAST_MV [8] = '{
        12'h73a, 12'h7d0, 12'h866, 12'h8fc,
        12'h992, 12'ha28, 12'habe, 12'hb54};
    localparam logic [MV_W-1:0] LVL_SLOW_MV [8] = '{
        12'h000, 12'h46a, 12'h4c4, 12'h514,
        12'h56e, 12'h5be, 12'h618, 12'h668};

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 40000;
    localparam int MIN_ON_US = 500;
    localparam int MIN_ON_CYC = (MIN_ON_US * CLK_KHZ + 999) / 1000;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // Detector state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_ON = 2'b01,
        ST_SETTLED = 2'b11
    } vdc_state_t;

endpackage

//--- tb/vdc_monitor.sv
// Purpose: Port assertions for the supply monitor control
// Assumes: Zero-wait APB, one clock
// Notes: Attached to vdc_ctrl by bind
`timescale 1ns/10ps
`default_nettype none
module vdc_monitor
    import vdc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic high_speed_oscillator,
    input wire logic detector_on,
    input wire logic [SEL_W-1:0] threshold_select,
    input wire logic [MV_W-1:0] threshold_mv,
    input wire logic threshold_valid
);
    // ----------
    // Properties
    // ----------
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic sel, ctl, acc, wsel, wctl;
    assign sel = paddr == ADDR_W'({IDX_THRESHOLD_SELECT, 2'b00});
    assign ctl = paddr == ADDR_W'({IDX_DETECTOR_CONTROL_RESULT, 2'b00});
    assign acc = psel && penable;
    assign wsel = acc && pwrite && sel;
    assign wctl = acc && pwrite && ctl;
    a_on_start: assert property (wctl && pwdata[0] |=> detector_on)
        else $error("detector did not start");
    a_on_stop: assert property (wctl && !pwdata[0] |=> !detector_on)
        else $error("detector did not stop");
    a_on_steady: assert property (!wctl |=> $stable(detector_on))
        else $error("detector changed unasked");
    a_sel_write:
        assert property (wsel |=> 32'(threshold_select) == ($past(pwdata) & 32'h7))
        else $error("select not written");
    a_ctl_read:
        assert property (acc && !pwrite && ctl |-> prdata[0] == detector_on
            && prdata[31:2] == 30'h0) else $error("control read wrong");
    a_sel_read:
        assert property (acc && !pwrite && sel |-> prdata == 32'(threshold_select))
        else $error("select read wrong");
    // Stability guards let either update style of the level pass
    a_fast_level:
        assert property (high_speed_oscillator && $stable(high_speed_oscillator)
            && $stable(threshold_select) |=> threshold_valid
            && threshold_mv == 1850 + 150 * $past(threshold_select))
        else $error("fast level wrong");
    a_slow_void:
        assert property (!high_speed_oscillator && $stable(high_speed_oscillator)
            && threshold_select == 3'h0 && $stable(threshold_select)
            |=> !threshold_valid && threshold_mv == 12'h0)
        else $error("slow code zero not void");
    cover property (wctl && !pwdata[0] && detector_on);
    cover property (wsel);
    cover property (acc && !pwrite && ctl && prdata[1]);
endmodule // vdc_monitor
bind vdc_ctrl vdc_monitor vdc_monitor_inst (.core_clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .high_speed_oscillator,
    .detector_on, .threshold_select, .threshold_mv, .threshold_valid);
`default_nettype wire

//--- tb/tb_supply_voltage_detect_control.sv
// Purpose: Directed self-checking bench for the supply monitor control
// Assumes: Zero-wait APB, short on-time parameter
// Notes: Each transfer ends on a falling edge so outputs have settled
`timescale 1ns/10ps
`default_nettype none
module tb_supply_voltage_detect_control import vdc_pkg::*;;
    localparam int ON_CYC = 8;
    localparam int SLOW_MV [8] = '{0, 1130, 1220, 1300, 1390, 1470, 1560, 1640};
    localparam logic [ADDR_W-1:0] A_SEL = ADDR_W'({IDX_THRESHOLD_SELECT, 2'b00});
    localparam logic [ADDR_W-1:0] A_CTL = A_SEL + 20'h4;
    localparam logic [ADDR_W-1:0] A_STS = A_SEL + 20'h8;
    localparam logic [ADDR_W-1:0] A_MSK = A_SEL + 20'hc;
    logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, high_speed_oscillator = 1'b0, supply_below = 1'b0;
    logic [ADDR_W-1:0] paddr = 20'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, detector_on, threshold_valid, irq, er;
    logic [SEL_W-1:0] threshold_select;
    logic [MV_W-1:0] threshold_mv;
    int bad_count = 0, compares = 0, cyc = 0;
    vdc_ctrl #(.MIN_ON_CYCLES(ON_CYC)) vdc_ctrl_inst (
        .core_clk(core_clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .high_speed_oscillator(high_speed_oscillator),
        .supply_below(supply_below),
        .detector_on(detector_on),
        .threshold_select(threshold_select),
        .threshold_mv(threshold_mv),
        .threshold_valid(threshold_valid),
        .irq(irq)
    );
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic summarize;
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge core_clk);
    endtask
    task automatic t_reset;
        apb(1'b0, A_SEL, 32'h0);
        chk("sel", 32'h0, rd);
        apb(1'b0, A_CTL, 32'h0);
        chk("ctl", 32'h0, rd);
        apb(1'b0, A_SEL + 20'h40, 32'h0);
        chk("bad", 32'h1, 32'(er));
    endtask
    task automatic t_levels;
        for (int o = 0; o < 2; o++) begin
            for (int i = 0; i < 8; i++) begin
                @(posedge core_clk);
                high_speed_oscillator <= o[0];
                apb(1'b1, A_SEL, 32'h8 + 32'(i));
                apb(1'b0, A_SEL, 32'h0);
                chk("sel", 32'(i), rd);
                chk("mv", 32'(o ? 1850 + 150 * i : SLOW_MV[i]), 32'(threshold_mv));
                chk("ok", 32'(o != 0 || i != 0), 32'(threshold_valid));
            end
        end
    endtask
    task automatic t_measure(input logic low);
        @(posedge core_clk);
        supply_below <= !low;
        apb(1'b1, A_CTL, 32'h1);
        chk("on", 32'h1, 32'(detector_on));
        repeat (ON_CYC + 4) @(posedge core_clk);
        supply_below <= low;
        apb(1'b1, A_CTL, 32'h0);
        chk("off", 32'h0, 32'(detector_on));
        apb(1'b0, A_CTL, 32'h0);
        chk("res", {30'h0, low, 1'b0}, rd);
        @(posedge core_clk);
        supply_below <= !low;
        apb(1'b1, A_CTL, 32'h2);
        apb(1'b0, A_CTL, 32'h0);
        chk("hold", {30'h0, low, 1'b0}, rd);
        apb(1'b1, A_CTL, 32'h1);
        apb(1'b0, A_CTL, 32'h0);
        chk("run", {30'h0, low, 1'b1}, rd);
        repeat (ON_CYC) @(posedge core_clk);
        apb(1'b1, A_CTL, 32'h0);
        apb(1'b0, A_CTL, 32'h0);
        chk("again", {30'h0, !low, 1'b0}, rd);
    endtask
    task automatic t_irq;
        apb(1'b0, A_STS, 32'h0);
        chk("sts", 32'h7, rd);
        chk("irq", 32'h0, 32'(irq));
        apb(1'b1, A_MSK, 32'h2);
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, A_STS, 32'h2);
        chk("irq", 32'h0, 32'(irq));
        apb(1'b0, A_STS, 32'h0);
        chk("sts", 32'h5, rd);
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_levels();
        t_measure(1'b1);
        t_irq();
        t_measure(1'b0);
        summarize();
    end
endmodule // tb_supply_voltage_detect_control
`default_nettype wire
